/* File: core/jog_slack_defines.vh */
// Constants for the jog, take-up-slack and crawl setpoint selector
// Overview of operation
// - Demand comes from the ramp path; output feeds the ramp generator input.
// - Run off and jog on substitutes a jog setpoint for ramp demand.
// - In jog, mode-select low picks jog setpoint one, high picks two.
// - Jog replaces both accel and decel ramp times with jog ramp time.
// - Jog forces the S-curve proportion to zero.
// - Run on with exactly one of jog and mode-select adds a take-up offset to the ramp demand.
// - Mode-select and jog together choose which take-up offset applies.
// - Run, jog and mode-select high output the crawl setpoint.
// - Run, jog, mode-select low give demand plus offset one, default ramp.
// - Run, no jog, mode-select high give demand plus offset two.
// - Contactor off in stop, on otherwise; stop and run pass demand.
// - Mode code: 0/1 stop, 2/3 jog, 4 run, 5/6 take-up, 7 crawl.
// - Setpoints and offsets are signed, -100.00 to 100.00 percent, 0.01 units; offsets are not clamped here, only their sum with the demand.
// - Jog ramp time in 0.1 s steps, 0.1 to 600.0 s, separate.
// - In jog, acceleration and deceleration times are always equal.
// - Direct setpoints are still summed onto the output for total demand.
// - Combined setpoint is a readable output in hundredths of a percent.
`ifndef JOG_SLACK_DEFINES_VH
`define JOG_SLACK_DEFINES_VH

// ****************************************************************
// Mode codes
// ****************************************************************
`define MODE_STOP_0     3'h0
`define MODE_STOP_1     3'h1
`define MODE_JOG_1      3'h2
`define MODE_JOG_2      3'h3
`define MODE_RUN        3'h4
`define MODE_TAKEUP_1   3'h5
`define MODE_TAKEUP_2   3'h6
`define MODE_CRAWL      3'h7

// ****************************************************************
// Value limits, hundredths of a percent / tenths of a second
// ****************************************************************
`define SP_FULL_SCALE   16'h2710
`define SP_NEG_SCALE    16'hD8F0
`define RT_MIN          13'h0001
`define RT_MAX          13'h1770
`define SCURVE_ZERO     16'h0000

`endif

/* File: core/jog_mode_decode.v */
// Mode decoder from run, jog and mode-select inputs
`timescale 1ns/1ps
`include "jog_slack_defines.vh"

module jog_mode_decode
(
    // Command inputs
    input  wire       i_run,
    input  wire       i_jog,
    input  wire       i_sel,
    // Decoded mode
    output reg  [2:0] o_mode
);

    // ************************************************************
    // Setpoint selection table
    // ************************************************************
    always @*
    begin
        case ({i_run, i_jog, i_sel})
            3'h0:    o_mode = `MODE_STOP_0;
            3'h1:    o_mode = `MODE_STOP_1;
            3'h2:    o_mode = `MODE_JOG_1;
            3'h3:    o_mode = `MODE_JOG_2;
            3'h4:    o_mode = `MODE_RUN;
            3'h5:    o_mode = `MODE_TAKEUP_2;
            3'h6:    o_mode = `MODE_TAKEUP_1;
            3'h7:    o_mode = `MODE_CRAWL;
            default: o_mode = `MODE_STOP_0;
        endcase
    end

endmodule // jog_mode_decode

/* File: core/jog_slack_setpoint_selector.v */
// Jog, take-up-slack and crawl setpoint selector for the speed path
`timescale 1ns/1ps
`include "jog_slack_defines.vh"

module jog_slack_setpoint_selector
#(
    parameter W  = 16,
    parameter TW = 13
)
(
    // Clock and reset
    input  wire                 i_clk,
    input  wire                 i_rst,
    // Commands from the sequence logic
    input  wire                 i_run_command_input,
    input  wire                 i_inch_command_input,
    input  wire                 i_mode_select,
    // Ramp path demand and direct setpoints
    input  wire signed [W-1:0]  i_ramp_demand,
    input  wire signed [W-1:0]  i_direct_setpoint,
    // Setpoints and offsets
    input  wire signed [W-1:0]  i_jog_speed_1,
    input  wire signed [W-1:0]  i_jog_speed_2,
    input  wire signed [W-1:0]  i_take_up_1,
    input  wire signed [W-1:0]  i_take_up_2,
    input  wire signed [W-1:0]  i_crawl_speed,
    // Ramp times, tenths of a second, and S-curve proportion
    input  wire        [TW-1:0] i_jog_ramp_time,
    input  wire        [TW-1:0] i_normal_accel_time,
    input  wire        [TW-1:0] i_normal_decel_time,
    input  wire        [W-1:0]  i_normal_scurve,
    // Outputs to the ramp generator
    output reg  signed [W-1:0]  o_ramp_input,
    output reg         [TW-1:0] o_accel_time,
    output reg         [TW-1:0] o_decel_time,
    output reg         [W-1:0]  o_scurve,
    output reg                  o_jog_ramp_active,
    // Diagnostics and contactor
    output reg  signed [W-1:0]  o_total_demand,
    output reg         [2:0]    o_selector_state_code,
    output reg                  o_contactor_request
);

    // ************************************************************
    // Local constants
    // ************************************************************
    // Slots of the setpoints that replace the demand outright
    localparam NSP      = 3;
    localparam SP_JOG_1 = 0;
    localparam SP_JOG_2 = 1;
    localparam SP_CRAWL = 2;

    // ************************************************************
    // Internal signals
    // ************************************************************
    wire        [2:0]       mode;
    wire                    jog_mode;
    wire                    stop_mode;
    wire        [NSP*W-1:0] sp_raw;
    wire        [NSP*W-1:0] sp_lim;
    wire signed [W-1:0]     jog_1_lim;
    wire signed [W-1:0]     jog_2_lim;
    wire signed [W-1:0]     crawl_lim;
    wire        [TW-1:0]    jog_rt;
    reg  signed [W-1:0]     demand_nxt;
    reg  signed [W-1:0]     total_nxt;
    reg         [TW-1:0]    accel_nxt;
    reg         [TW-1:0]    decel_nxt;
    reg         [W-1:0]     scurve_nxt;
    reg                     contactor_nxt;
    reg         [2:0]       code_nxt;
    reg                     jog_flag_nxt;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Clamp to full scale so an offset cannot wrap the demand sign
    function signed [W-1:0] sat;
        input signed [W:0] v;
        begin
            if (v > $signed({1'b0, `SP_FULL_SCALE}))
                sat = `SP_FULL_SCALE;
            else if (v < $signed({1'b1, `SP_NEG_SCALE}))
                sat = `SP_NEG_SCALE;
            else
                sat = v[W-1:0];
        end
    endfunction

    // Widen by one bit first so the raw sum never overflows
    function signed [W-1:0] add_sat;
        input signed [W-1:0] a;
        input signed [W-1:0] b;
        begin
            add_sat = sat({a[W-1], a} + {b[W-1], b});
        end
    endfunction

    function signed [W-1:0] lim;
        input signed [W-1:0] a;
        begin
            lim = sat({a[W-1], a});
        end
    endfunction

    // Out-of-range jog ramp times are pinned, not refused
    function [TW-1:0] clamp_time;
        input [TW-1:0] t;
        begin
            if (t < `RT_MIN)
                clamp_time = `RT_MIN;
            else if (t > `RT_MAX)
                clamp_time = `RT_MAX;
            else
                clamp_time = t;
        end
    endfunction

    function is_jog;
        input [2:0] m;
        begin
            is_jog = (m == `MODE_JOG_1) || (m == `MODE_JOG_2);
        end
    endfunction

    function is_stop;
        input [2:0] m;
        begin
            is_stop = (m == `MODE_STOP_0) || (m == `MODE_STOP_1);
        end
    endfunction

    // ************************************************************
    // Mode decode
    // ************************************************************
    jog_mode_decode u_decode
    (
        .i_run  (i_run_command_input),
        .i_jog  (i_inch_command_input),
        .i_sel  (i_mode_select),
        .o_mode (mode)
    );

    // ************************************************************
    // Mode classification
    // ************************************************************
    assign jog_mode  = is_jog(mode);
    assign stop_mode = is_stop(mode);

    // ************************************************************
    // Setpoint limiting
    // ************************************************************
    assign sp_raw = {i_crawl_speed, i_jog_speed_2, i_jog_speed_1};

    genvar g;
    generate
        for (g = 0; g < NSP; g = g + 1)
        begin : g_limit
            assign sp_lim[g*W +: W] = lim(sp_raw[g*W +: W]);
        end
    endgenerate

    assign jog_1_lim = sp_lim[SP_JOG_1*W +: W];
    assign jog_2_lim = sp_lim[SP_JOG_2*W +: W];
    assign crawl_lim = sp_lim[SP_CRAWL*W +: W];
    assign jog_rt    = clamp_time(i_jog_ramp_time);

    // ************************************************************
    // Demand selection
    // ************************************************************
    // Take-up offsets go in unclamped; only the sum is limited
    always @*
    begin
        case (mode)
            `MODE_JOG_1:    demand_nxt = jog_1_lim;
            `MODE_JOG_2:    demand_nxt = jog_2_lim;
            `MODE_TAKEUP_1: demand_nxt = add_sat(i_ramp_demand,
                                                 i_take_up_1);
            `MODE_TAKEUP_2: demand_nxt = add_sat(i_ramp_demand,
                                                 i_take_up_2);
            `MODE_CRAWL:    demand_nxt = crawl_lim;
            default:        demand_nxt = i_ramp_demand;
        endcase
    end

    // Direct setpoints still land on the total, even in jog
    always @*
    begin
        total_nxt = add_sat(demand_nxt, i_direct_setpoint);
    end

    // ************************************************************
    // Ramp time selection
    // ************************************************************
    always @*
    begin
        if (jog_mode)
        begin
            accel_nxt  = jog_rt;
            decel_nxt  = jog_rt;
            scurve_nxt = `SCURVE_ZERO;
        end
        else
        begin
            accel_nxt  = i_normal_accel_time;
            decel_nxt  = i_normal_decel_time;
            scurve_nxt = i_normal_scurve;
        end
    end

    // ************************************************************
    // Contactor request
    // ************************************************************
    always @*
    begin
        contactor_nxt = !stop_mode;
    end

    // ************************************************************
    // Status selection
    // ************************************************************
    always @*
    begin
        code_nxt     = mode;
        jog_flag_nxt = jog_mode;
    end

    // ************************************************************
    // Registered demand outputs
    // ************************************************************
    // One process per output keeps each reset value beside its source
    always @(posedge i_clk)
    begin
        if (i_rst)
            o_ramp_input <= {W{1'b0}};
        else
            o_ramp_input <= demand_nxt;
    end

    always @(posedge i_clk)
    begin
        if (i_rst)
            o_total_demand <= {W{1'b0}};
        else
            o_total_demand <= total_nxt;
    end

    // ************************************************************
    // Registered ramp outputs
    // ************************************************************
    always @(posedge i_clk)
    begin
        if (i_rst)
            o_accel_time <= {TW{1'b0}};
        else
            o_accel_time <= accel_nxt;
    end

    always @(posedge i_clk)
    begin
        if (i_rst)
            o_decel_time <= {TW{1'b0}};
        else
            o_decel_time <= decel_nxt;
    end

    always @(posedge i_clk)
    begin
        if (i_rst)
            o_scurve <= {W{1'b0}};
        else
            o_scurve <= scurve_nxt;
    end

    always @(posedge i_clk)
    begin
        if (i_rst)
            o_jog_ramp_active <= 1'b0;
        else
            o_jog_ramp_active <= jog_flag_nxt;
    end

    // ************************************************************
    // Registered status outputs
    // ************************************************************
    // Reset lands in stop with the contactor dropped
    always @(posedge i_clk)
    begin
        if (i_rst)
            o_selector_state_code <= `MODE_STOP_0;
        else
            o_selector_state_code <= code_nxt;
    end

    always @(posedge i_clk)
    begin
        if (i_rst)
            o_contactor_request <= 1'b0;
        else
            o_contactor_request <= contactor_nxt;
    end

endmodule // jog_slack_setpoint_selector

/* File: sim/seq_partner.sv */
// Sequencer model driving run, jog and mode-select commands
`timescale 1ns/1ps
module seq_partner (
    // Requested command set
    input  wire logic [2:0] i_req,
    // Commands to the selector
    output wire logic       o_run,
    output wire logic       o_jog,
    output wire logic       o_sel
);
    // One assignment, so run, jog and mode-select all update at the same instant
    assign {o_run, o_jog, o_sel} = i_req;
endmodule // seq_partner

/* File: sim/jog_slack_assertions.sv */
// Assertion checker for the setpoint selector
`timescale 1ns/1ps
module jog_slack_checker (
    input wire        i_clk,
    input wire        i_rst,
    input wire        i_run_command_input,
    input wire        i_inch_command_input,
    input wire        i_mode_select,
    input wire [12:0] o_accel_time,
    input wire [12:0] o_decel_time,
    input wire [15:0] o_scurve,
    input wire        o_jog_ramp_active,
    input wire [2:0]  o_selector_state_code,
    input wire        o_contactor_request
);
    wire       r = i_run_command_input;
    wire       j = i_inch_command_input;
    wire       s = i_mode_select;
    wire [2:0] m = o_selector_state_code;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_crawl;
        r && j && s;
    endsequence
    a_jog_times_equal: assert property (
        o_jog_ramp_active |-> o_accel_time == o_decel_time) else $error("ramp");
    a_jog_scurve_zero: assert property (
        o_jog_ramp_active |-> o_scurve == 16'h0000) else $error("scurve");
    a_contactor_mode: assert property (
        o_contactor_request == (m > 3'h1)) else $error("contactor");
    a_jog_flag_mode: assert property (
        o_jog_ramp_active == (m[2:1] == 2'h1)) else $error("jog flag");
    a_jog_select: assert property (
        !r && j |=> m == {2'h1, $past(s)}) else $error("jog code");
    a_crawl_code: assert property (
        s_crawl |=> m == 3'h7) else $error("crawl code");
    a_takeup_one: assert property (
        r && j && !s |=> m == 3'h5) else $error("take-up one code");
    a_takeup_two: assert property (
        r && !j && s |=> m == 3'h6) else $error("take-up two code");
    a_reset_stop: assert property (disable iff (1'b0)
        i_rst |=> m == 3'h0 && !o_contactor_request) else $error("reset");
endmodule // jog_slack_checker
bind jog_slack_setpoint_selector jog_slack_checker i_chk (
    .i_clk                 (i_clk),
    .i_rst                 (i_rst),
    .i_run_command_input   (i_run_command_input),
    .i_inch_command_input  (i_inch_command_input),
    .i_mode_select         (i_mode_select),
    .o_accel_time          (o_accel_time),
    .o_decel_time          (o_decel_time),
    .o_scurve              (o_scurve),
    .o_jog_ramp_active     (o_jog_ramp_active),
    .o_selector_state_code (o_selector_state_code),
    .o_contactor_request   (o_contactor_request)
);

/* File: sim/tb.sv */
// Self-checking bench for the setpoint selector
`timescale 1ns/1ps
module tb;
    logic clk = 0, rst = 1, run, jog, sel, jra, con;
    logic [2:0] req = 0, code;
    logic signed [15:0] dm = 0, dr = 0, j1 = 0, j2 = 0, t1 = 0, t2 = 0;
    logic signed [15:0] cr = 0, rin, tot;
    logic [12:0] jt = 0, at = 0, dt = 0, oa, od;
    logic [15:0] sc = 0, osc;
    int num_errors = 0, cmp_count = 0, cyc = 0, ec, er, et;
    initial forever #12.5 clk = ~clk;
    seq_partner i_seq (.i_req(req), .o_run(run), .o_jog(jog), .o_sel(sel));
    jog_slack_setpoint_selector i_dut (.i_clk(clk), .i_rst(rst),
        .i_run_command_input(run), .i_inch_command_input(jog),
        .i_mode_select(sel), .i_ramp_demand(dm), .i_direct_setpoint(dr),
        .i_jog_speed_1(j1), .i_jog_speed_2(j2), .i_take_up_1(t1),
        .i_take_up_2(t2), .i_crawl_speed(cr), .i_jog_ramp_time(jt),
        .i_normal_accel_time(at), .i_normal_decel_time(dt),
        .i_normal_scurve(sc), .o_ramp_input(rin), .o_accel_time(oa),
        .o_decel_time(od), .o_scurve(osc), .o_jog_ramp_active(jra),
        .o_total_demand(tot), .o_selector_state_code(code),
        .o_contactor_request(con));
    function automatic int sat(int v);
        return v > 10000 ? 10000 : (v < -10000 ? -10000 : v);
    endfunction
    function automatic logic [15:0] rv();
        return 16'($urandom_range(24000) - 12000);
    endfunction
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            summarize();
        end
    end
    task automatic step(logic [2:0] r);
        @(posedge clk);
        #2;
        req = r;
        {dm, dr, j1, j2} = {rv(), rv(), rv(), rv()};
        {t1, t2, cr, sc} = {rv(), rv(), rv(), rv()};
        {jt, at, dt} = {13'($urandom), 13'($urandom), 13'($urandom)};
        ec = r == 5 ? 6 : (r == 6 ? 5 : r);
        er = ec == 2 ? sat(j1) : ec == 3 ? sat(j2) : ec == 5 ? sat(dm + t1)
           : ec == 6 ? sat(dm + t2) : ec == 7 ? sat(cr) : dm;
        et = jt == 0 ? 1 : (jt > 6000 ? 6000 : jt);
        @(posedge clk);
        #1;
        chk("code", 16'(ec), 16'(code));
        chk("ramp", 16'(er), rin);
        chk("total", 16'(sat(er + dr)), tot);
        chk("contactor", 16'(ec > 1), 16'(con));
        chk("accel", 16'(ec inside {2, 3} ? et : at), 16'(oa));
        chk("decel", 16'(ec inside {2, 3} ? et : dt), 16'(od));
        chk("scurve", ec inside {2, 3} ? 16'h0000 : sc, osc);
        chk("jog flag", 16'(ec inside {2, 3}), 16'(jra));
    endtask
    initial
    begin
        void'($urandom(32'h52AB));
        repeat (16) @(posedge clk);
        #2;
        rst = 0;
        for (int r = 0; r < 8; r++)
            step(3'(r));
        repeat (300)
            step(3'($urandom_range(7)));
        @(posedge clk);
        #2;
        rst = 1;
        @(posedge clk);
        #1;
        chk("reset code", 16'h0000, 16'(code));
        chk("reset contactor", 16'h0000, 16'(con));
        chk("reset ramp", 16'h0000, rin);
        chk("reset total", 16'h0000, tot);
        chk("reset accel", 16'h0000, 16'(oa));
        chk("reset decel", 16'h0000, 16'(od));
        chk("reset scurve", 16'h0000, osc);
        chk("reset jog flag", 16'h0000, 16'(jra));
        @(posedge clk);
        #2;
        rst = 0;
        for (int r = 0; r < 8; r++)
            step(3'(r));
        summarize();
    end
endmodule // tb
